// File: core/lra_buf_if.sv
// carrier between the top and the frame data buffer
`timescale 1ns/1ns
interface lra_buf_if;
   logic                 sw_we;
   logic [2:0]           sw_idx;
   lra_pkg::lra_byte_type sw_wdata;
   logic                 eng_we;
   logic [2:0]           eng_idx;
   lra_pkg::lra_byte_type eng_wdata;
   logic [2:0]           rd_idx;
   lra_pkg::lra_byte_type rd_data;
   logic [2:0]           eng_rd_idx;
   lra_pkg::lra_byte_type eng_rd_data;
   modport host (output sw_we, sw_idx, sw_wdata, eng_we, eng_idx, eng_wdata,
                 output rd_idx, eng_rd_idx, input rd_data, eng_rd_data);
   modport mem  (input sw_we, sw_idx, sw_wdata, eng_we, eng_idx, eng_wdata,
                 input rd_idx, eng_rd_idx, output rd_data, eng_rd_data);
endinterface // lra_buf_if

// File: core/lra_data_buf.sv
// eight-byte frame data buffer with registered read ports
`timescale 1ns/1ns
module lra_data_buf #(
   parameter int DEPTH = 8
) (
   // clock and control
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic ce_i,
   // buffer ports
   lra_buf_if.mem    bus
);
   lra_pkg::lra_byte_type mem_r [DEPTH];

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            mem_r[i] <= 8'h00;
         end
      end else if (ce_i) begin
         for (int i = 0; i < DEPTH; i++) begin
            // engine receive wins a same-byte collision: the bus owns the frame
            if (bus.eng_we && (int'(bus.eng_idx) == i)) begin
               mem_r[i] <= bus.eng_wdata;
            end else if (bus.sw_we && (int'(bus.sw_idx) == i)) begin
               mem_r[i] <= bus.sw_wdata;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         bus.rd_data     <= 8'h00;
         bus.eng_rd_data <= 8'h00;
      end else if (ce_i) begin
         bus.rd_data     <= mem_r[bus.rd_idx];
         bus.eng_rd_data <= mem_r[bus.eng_rd_idx];
      end
   end
endmodule // lra_data_buf

// File: core/lra_defs.svh
// register addresses, indirect indices, field positions and reset values
`ifndef LRA_DEFS_SVH
`define LRA_DEFS_SVH

// -----------------------------------------------------------------
// direct register decode
// -----------------------------------------------------------------
`define LRA_PAGE_LIN      8'h00
`define LRA_PAGE_CFG      8'h0F
`define LRA_ADDR_PTR      8'hD3
`define LRA_ADDR_WIN      8'hD2
`define LRA_ADDR_CFG      8'hC9

// -----------------------------------------------------------------
// indirect register indices
// -----------------------------------------------------------------
`define LRA_IDX_DATA_LAST 8'h07
`define LRA_IDX_CTRL      8'h08
`define LRA_IDX_STAT      8'h09
`define LRA_IDX_FAULT     8'h0A
`define LRA_IDX_SIZE      8'h0B
`define LRA_IDX_DIV       8'h0C
`define LRA_IDX_MUL       8'h0D
`define LRA_IDX_ID        8'h0E

// -----------------------------------------------------------------
// field positions
// -----------------------------------------------------------------
`define LRA_CFG_ON        7
`define LRA_CFG_ROLE      6
`define LRA_CFG_AUTO      5
`define LRA_CTRL_STOP     7
`define LRA_CTRL_SLEEP    6
`define LRA_CTRL_TXRX     5
`define LRA_CTRL_DTACK    4
`define LRA_CTRL_IRQCLR   3
`define LRA_CTRL_FLTCLR   2
`define LRA_CTRL_WUP      1
`define LRA_CTRL_GO       0

// -----------------------------------------------------------------
// masks and reset values
// -----------------------------------------------------------------
`define LRA_MASK_FULL     8'hFF
`define LRA_MASK_CFG      8'hE0
`define LRA_MASK_SIZE     8'h8F
`define LRA_MASK_ID       8'h3F
`define LRA_MASK_FAULT    8'h1F
`define LRA_CTRL_STORE    8'h73
`define LRA_CTRL_SLAVE    8'hD0
`define LRA_CTRL_MASTER   8'h01
`define LRA_STAT_SLAVE    8'h30
`define LRA_FAULT_SLAVE   8'h18
`define LRA_RST_ZERO      8'h00
`define LRA_RST_CFG       8'h60

`endif

// File: core/lra_field_reg.sv
// one masked read/write byte register
`timescale 1ns/1ns
module lra_field_reg #(
   parameter logic [7:0] MASK  = 8'hFF,
   parameter logic [7:0] RESET = 8'h00
) (
   // clock and control
   input  wire logic       clk_i,
   input  wire logic       rst_n_i,
   input  wire logic       ce_i,
   // write port
   input  wire logic       we_i,
   input  wire logic [7:0] wdata_i,
   // contents
   output logic [7:0]      q_o
);
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         q_o <= RESET & MASK;
      end else if (ce_i && we_i) begin
         // unused bits never store, so they read back as zero
         q_o <= wdata_i & MASK;
      end
   end
endmodule // lra_field_reg

// File: core/lra_pkg.sv
// shared types of the register access block
package lra_pkg;
   typedef logic [7:0] lra_byte_type;
   typedef enum {LRA_SEL_NONE, LRA_SEL_PTR, LRA_SEL_WIN, LRA_SEL_CFG} lra_rdsel_type;
endpackage

// File: core/lra_top.sv
// register access front end of the LIN controller
`timescale 1ns/1ns
`include "lra_defs.svh"

module lra_top (
   // clock, reset, enable
   input  wire logic       CLK_I,
   input  wire logic       RST_N_I,
   input  wire logic       CE_I,
   // special function register bus
   input  wire logic [7:0] SFR_ADDR_I,
   input  wire logic [7:0] SFR_PAGE_I,
   input  wire logic       SFR_WR_I,
   input  wire logic       SFR_RD_I,
   input  wire logic [7:0] SFR_WDATA_I,
   output logic      [7:0] SFR_RDATA_O,
   output logic            SFR_RVALID_O,
   // frame engine events and state
   input  wire logic       ENG_DONE_I,
   input  wire logic       ENG_ERROR_I,
   input  wire logic       ENG_ACK_CLR_I,
   input  wire logic       ENG_WUP_CLR_I,
   input  wire logic [7:0] ENG_STATUS_I,
   input  wire logic [4:0] ENG_FAULT_I,
   // frame engine buffer access
   input  wire logic       ENG_DATA_WE_I,
   input  wire logic [2:0] ENG_DATA_IDX_I,
   input  wire logic [7:0] ENG_DATA_I,
   input  wire logic [2:0] ENG_RD_IDX_I,
   output logic      [7:0] ENG_RD_DATA_O,
   // configuration to the engine
   output logic            IF_ON_O,
   output logic            MASTER_O,
   output logic            AUTO_RATE_O,
   // control to the engine
   output logic            SLEEP_O,
   output logic            TX_SEL_O,
   output logic            SLAVE_ACK_O,
   output logic            WAKE_REQ_O,
   output logic            MASTER_GO_O,
   output logic            STOP_O,
   output logic            IRQ_CLEAR_O,
   output logic            FAULT_CLEAR_O,
   // frame setup to the engine
   output logic      [7:0] SIZE_O,
   output logic      [7:0] DIV_O,
   output logic      [7:0] MUL_O,
   output logic      [7:0] ID_O
);

   // -----------------------------------------------------------------
   // direct decode
   // -----------------------------------------------------------------
   logic                    ptr_hit;
   logic                    win_hit;
   logic                    cfg_hit;
   logic                    ptr_we;
   logic                    win_we;
   logic                    cfg_we;
   logic [7:0]              ptr_q;
   logic [7:0]              cfg_q;
   logic                    is_master;
   lra_pkg::lra_rdsel_type  rd_sel_nxt;

   always_comb begin
      ptr_hit    = 1'b0;
      win_hit    = 1'b0;
      cfg_hit    = 1'b0;
      rd_sel_nxt = lra_pkg::LRA_SEL_NONE;
      if ((SFR_PAGE_I == `LRA_PAGE_LIN) && (SFR_ADDR_I == `LRA_ADDR_PTR)) begin
         ptr_hit    = 1'b1;
         rd_sel_nxt = lra_pkg::LRA_SEL_PTR;
      end else if ((SFR_PAGE_I == `LRA_PAGE_LIN) && (SFR_ADDR_I == `LRA_ADDR_WIN)) begin
         win_hit    = 1'b1;
         rd_sel_nxt = lra_pkg::LRA_SEL_WIN;
      end else if ((SFR_PAGE_I == `LRA_PAGE_CFG) && (SFR_ADDR_I == `LRA_ADDR_CFG)) begin
         cfg_hit    = 1'b1;
         rd_sel_nxt = lra_pkg::LRA_SEL_CFG;
      end
   end

   assign ptr_we    = SFR_WR_I && ptr_hit;
   assign win_we    = SFR_WR_I && win_hit;
   assign cfg_we    = SFR_WR_I && cfg_hit;
   assign is_master = cfg_q[`LRA_CFG_ROLE];

   // -----------------------------------------------------------------
   // pointer, configuration and frame setup registers
   // -----------------------------------------------------------------
   logic       size_we;
   logic       div_we;
   logic       mul_we;
   logic       id_we;
   logic       ctrl_we;

   // window writes land only on a mapped index
   assign size_we = win_we && (ptr_q == `LRA_IDX_SIZE);
   assign div_we  = win_we && (ptr_q == `LRA_IDX_DIV);
   assign mul_we  = win_we && (ptr_q == `LRA_IDX_MUL);
   assign id_we   = win_we && (ptr_q == `LRA_IDX_ID);
   assign ctrl_we = win_we && (ptr_q == `LRA_IDX_CTRL);

   lra_field_reg #(.MASK(`LRA_MASK_FULL), .RESET(`LRA_RST_ZERO)) u_ptr (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I),
      .we_i(ptr_we), .wdata_i(SFR_WDATA_I), .q_o(ptr_q));
   // low five bits are not stored at all
   lra_field_reg #(.MASK(`LRA_MASK_CFG), .RESET(`LRA_RST_CFG)) u_cfg (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I),
      .we_i(cfg_we), .wdata_i(SFR_WDATA_I), .q_o(cfg_q));
   lra_field_reg #(.MASK(`LRA_MASK_SIZE), .RESET(`LRA_RST_ZERO)) u_size (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I),
      .we_i(size_we), .wdata_i(SFR_WDATA_I), .q_o(SIZE_O));
   lra_field_reg #(.MASK(`LRA_MASK_FULL), .RESET(`LRA_RST_ZERO)) u_div (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I),
      .we_i(div_we), .wdata_i(SFR_WDATA_I), .q_o(DIV_O));
   lra_field_reg #(.MASK(`LRA_MASK_FULL), .RESET(`LRA_RST_ZERO)) u_mul (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I),
      .we_i(mul_we), .wdata_i(SFR_WDATA_I), .q_o(MUL_O));
   lra_field_reg #(.MASK(`LRA_MASK_ID), .RESET(`LRA_RST_ZERO)) u_id (
      .clk_i(CLK_I), .rst_n_i(RST_N_I), .ce_i(CE_I),
      .we_i(id_we), .wdata_i(SFR_WDATA_I), .q_o(ID_O));

   assign IF_ON_O     = cfg_q[`LRA_CFG_ON];
   assign MASTER_O    = is_master;
   assign AUTO_RATE_O = cfg_q[`LRA_CFG_AUTO] && !is_master;

   // -----------------------------------------------------------------
   // data buffer
   // -----------------------------------------------------------------
   lra_buf_if buf_if ();

   assign buf_if.sw_we      = win_we && (ptr_q <= `LRA_IDX_DATA_LAST);
   assign buf_if.sw_idx     = ptr_q[2:0];
   assign buf_if.sw_wdata   = SFR_WDATA_I;
   assign buf_if.eng_we     = ENG_DATA_WE_I;
   assign buf_if.eng_idx    = ENG_DATA_IDX_I;
   assign buf_if.eng_wdata  = ENG_DATA_I;
   assign buf_if.rd_idx     = ptr_q[2:0];
   assign buf_if.eng_rd_idx = ENG_RD_IDX_I;
   assign ENG_RD_DATA_O     = buf_if.eng_rd_data;

   lra_data_buf #(.DEPTH(8)) u_buf (
      .clk_i  (CLK_I),
      .rst_n_i(RST_N_I),
      .ce_i   (CE_I),
      .bus    (buf_if.host)
   );

   // -----------------------------------------------------------------
   // frame control register
   // -----------------------------------------------------------------
   logic [7:0] ctrl_r;
   logic [7:0] ctrl_nxt;
   logic [7:0] ctrl_wmask;
   logic [7:0] role_block;

   // bits owned by the other role are frozen and hidden
   assign role_block = is_master ? `LRA_CTRL_SLAVE : `LRA_CTRL_MASTER;
   assign ctrl_wmask = `LRA_CTRL_STORE & ~role_block;

   always_comb begin
      ctrl_nxt = ctrl_r;
      if (ENG_DONE_I || ENG_ERROR_I) begin
         ctrl_nxt[`LRA_CTRL_GO] = 1'b0;
      end
      if (ENG_ACK_CLR_I) begin
         ctrl_nxt[`LRA_CTRL_DTACK] = 1'b0;
      end
      if (ENG_WUP_CLR_I) begin
         ctrl_nxt[`LRA_CTRL_WUP] = 1'b0;
      end
      // a fresh software request in the same cycle outlives the auto-clear
      if (ctrl_we) begin
         ctrl_nxt = (SFR_WDATA_I & ctrl_wmask) | (ctrl_nxt & ~ctrl_wmask);
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         ctrl_r <= `LRA_RST_ZERO;
      end else if (CE_I) begin
         ctrl_r <= ctrl_nxt;
      end
   end

   // strobes: one-cycle pulses, nothing stored
   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         STOP_O        <= 1'b0;
         IRQ_CLEAR_O   <= 1'b0;
         FAULT_CLEAR_O <= 1'b0;
      end else if (CE_I) begin
         STOP_O        <= ctrl_we && SFR_WDATA_I[`LRA_CTRL_STOP] && !is_master;
         IRQ_CLEAR_O   <= ctrl_we && SFR_WDATA_I[`LRA_CTRL_IRQCLR];
         FAULT_CLEAR_O <= ctrl_we && SFR_WDATA_I[`LRA_CTRL_FLTCLR];
      end
   end

   assign SLEEP_O     = ctrl_r[`LRA_CTRL_SLEEP];
   assign TX_SEL_O    = ctrl_r[`LRA_CTRL_TXRX];
   assign SLAVE_ACK_O = ctrl_r[`LRA_CTRL_DTACK];
   assign WAKE_REQ_O  = ctrl_r[`LRA_CTRL_WUP];
   assign MASTER_GO_O = ctrl_r[`LRA_CTRL_GO];

   // -----------------------------------------------------------------
   // read path: two cycles, buffer read register sits in the middle
   // -----------------------------------------------------------------
   logic                   rd_pend_r;
   lra_pkg::lra_rdsel_type rd_sel_r;
   logic [7:0]             rd_ptr_r;
   logic [7:0]             ind_view;

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         rd_pend_r <= 1'b0;
         rd_sel_r  <= lra_pkg::LRA_SEL_NONE;
         rd_ptr_r  <= 8'h00;
      end else if (CE_I) begin
         rd_pend_r <= SFR_RD_I;
         rd_sel_r  <= rd_sel_nxt;
         rd_ptr_r  <= ptr_q;
      end
   end

   always_comb begin
      if (rd_ptr_r <= `LRA_IDX_DATA_LAST) begin
         ind_view = buf_if.rd_data;
      end else if (rd_ptr_r == `LRA_IDX_CTRL) begin
         ind_view = ctrl_r & ctrl_wmask;
      end else if (rd_ptr_r == `LRA_IDX_STAT) begin
         ind_view = ENG_STATUS_I & ~(is_master ? `LRA_STAT_SLAVE : `LRA_RST_ZERO);
      end else if (rd_ptr_r == `LRA_IDX_FAULT) begin
         ind_view = {3'b000, ENG_FAULT_I} & `LRA_MASK_FAULT
                    & ~(is_master ? `LRA_FAULT_SLAVE : `LRA_RST_ZERO);
      end else if (rd_ptr_r == `LRA_IDX_SIZE) begin
         ind_view = SIZE_O;
      end else if (rd_ptr_r == `LRA_IDX_DIV) begin
         ind_view = DIV_O;
      end else if (rd_ptr_r == `LRA_IDX_MUL) begin
         ind_view = MUL_O;
      end else if (rd_ptr_r == `LRA_IDX_ID) begin
         ind_view = ID_O;
      end else begin
         ind_view = 8'h00;
      end
   end

   always_ff @(posedge CLK_I) begin
      if (!RST_N_I) begin
         SFR_RDATA_O  <= 8'h00;
         SFR_RVALID_O <= 1'b0;
      end else if (CE_I) begin
         SFR_RVALID_O <= rd_pend_r;
         if (rd_pend_r) begin
            if (rd_sel_r == lra_pkg::LRA_SEL_PTR) begin
               SFR_RDATA_O <= ptr_q;
            end else if (rd_sel_r == lra_pkg::LRA_SEL_WIN) begin
               SFR_RDATA_O <= ind_view;
            end else if (rd_sel_r == lra_pkg::LRA_SEL_CFG) begin
               SFR_RDATA_O <= cfg_q;
            end else begin
               SFR_RDATA_O <= 8'h00;
            end
         end
      end
   end

   // -----------------------------------------------------------------
   // assertions
   // -----------------------------------------------------------------
   a_ptr_write_lands: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && ptr_we) |=> (ptr_q == $past(SFR_WDATA_I)))
      else $error("pointer write not stored");

   a_id_write_lands: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && win_we && ptr_q == `LRA_IDX_ID) |=> (ID_O == ($past(SFR_WDATA_I) & `LRA_MASK_ID)))
      else $error("window write to identifier lost");

   a_size_read_back: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && SFR_RD_I && win_hit && ptr_q == `LRA_IDX_SIZE && !size_we ##1 CE_I && !SFR_WR_I
       ##1 CE_I) |-> (SFR_RVALID_O && SFR_RDATA_O == SIZE_O))
      else $error("window read of size wrong");

   a_enable_follows: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && cfg_we) |=> (IF_ON_O == $past(SFR_WDATA_I[7])))
      else $error("enable bit not applied");

   a_role_follows: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && cfg_we) |=> (MASTER_O == $past(SFR_WDATA_I[6])))
      else $error("role bit not applied");

   a_auto_rate_gate: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      MASTER_O |-> !AUTO_RATE_O)
      else $error("automatic rate active in master mode");

   a_cfg_low_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (SFR_RVALID_O && $past(rd_sel_r) == lra_pkg::LRA_SEL_CFG && $past(CE_I))
      |-> (SFR_RDATA_O[4:0] == 5'b00000))
      else $error("config low bits not zero");

   a_ptr_page_decode: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && SFR_WR_I && SFR_ADDR_I == `LRA_ADDR_PTR && SFR_PAGE_I != `LRA_PAGE_LIN)
      |=> $stable(ptr_q))
      else $error("pointer written on wrong page");

   a_cfg_page_decode: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && SFR_WR_I && SFR_ADDR_I == `LRA_ADDR_CFG && SFR_PAGE_I != `LRA_PAGE_CFG)
      |=> $stable(cfg_q))
      else $error("config written on wrong page");

   a_slave_bits_held: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && ctrl_we && is_master && !SLAVE_ACK_O && !ENG_ACK_CLR_I) |=> !SLAVE_ACK_O)
      else $error("slave acknowledge set in master mode");

   a_strobe_one_cycle: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && IRQ_CLEAR_O && !(ctrl_we && SFR_WDATA_I[`LRA_CTRL_IRQCLR])) |=> !IRQ_CLEAR_O)
      else $error("interrupt clear strobe held");

   a_go_self_clear: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && MASTER_GO_O && (ENG_DONE_I || ENG_ERROR_I) && !ctrl_we) |=> !MASTER_GO_O)
      else $error("start request not cleared");

   a_unmapped_zero: assert property (@(posedge CLK_I) disable iff (!RST_N_I)
      (CE_I && SFR_RD_I && win_hit && ptr_q > `LRA_IDX_ID ##1 CE_I ##1 CE_I)
      |-> (SFR_RVALID_O && SFR_RDATA_O == 8'h00))
      else $error("unmapped window read not zero");

endmodule // lra_top

// File: tb/lra_cpu_model.sv
// processor core model that drives the register bus
`timescale 1ns/1ns
module lra_cpu_model (
   // clock
   input  wire logic       clk_i,
   // register bus
   output logic      [7:0] addr_o,
   output logic      [7:0] page_o,
   output logic            wr_o,
   output logic            rd_o,
   output logic      [7:0] wdata_o
);
   initial begin
      addr_o  = 8'h00;
      page_o  = 8'h00;
      wr_o    = 1'b0;
      rd_o    = 1'b0;
      wdata_o = 8'h00;
   end

   // one strobe cycle, taken at the edge on which the task returns
   task automatic access(input logic w, input logic [7:0] a, p, d);
      @(posedge clk_i);
      addr_o  <= a;
      page_o  <= p;
      wdata_o <= d;
      wr_o    <= w;
      rd_o    <= !w;
      @(posedge clk_i);
      wr_o    <= 1'b0;
      rd_o    <= 1'b0;
      // released lines carry the inverted address, page and data, so a stale value cannot pass for a match
      addr_o  <= ~a;
      page_o  <= ~p;
      wdata_o <= ~d;
   endtask
endmodule // lra_cpu_model

// File: tb/lra_top_tb.sv
// self-checking bench of the register access block
`timescale 1ns/1ns
`include "lra_defs.svh"
module lra_top_tb;
   logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1;
   logic [7:0] addr, page, wdata, rdata, st = 8'h00, eng_d = 8'h00, v, erd;
   logic wr, rd, rvalid, eng_we = 1'b0, on, mst, aut, slp, txs, ack, wup, go, stp, irq, flt;
   logic [3:0] ev_r = 4'h0;
   logic [4:0] fl = 5'h00;
   logic [2:0] eidx = 3'h0, ridx = 3'h0;
   logic [7:0] sz, dv, ml, id;
   logic [7:0] d [15];
   logic [7:0] q [$];
   int n_fail = 0, tests_run = 0;

   always #5 clk = ~clk;

   lra_cpu_model cpu_i (.clk_i(clk), .addr_o(addr), .page_o(page), .wr_o(wr), .rd_o(rd),
      .wdata_o(wdata));

   lra_top lra_top_i (.CLK_I(clk), .RST_N_I(rst_n), .CE_I(ce), .SFR_ADDR_I(addr),
      .SFR_PAGE_I(page), .SFR_WR_I(wr), .SFR_RD_I(rd), .SFR_WDATA_I(wdata),
      .SFR_RDATA_O(rdata), .SFR_RVALID_O(rvalid), .ENG_DONE_I(ev_r[3]),
      .ENG_ERROR_I(ev_r[2]), .ENG_ACK_CLR_I(ev_r[1]), .ENG_WUP_CLR_I(ev_r[0]),
      .ENG_STATUS_I(st), .ENG_FAULT_I(fl), .ENG_DATA_WE_I(eng_we), .ENG_DATA_IDX_I(eidx),
      .ENG_DATA_I(eng_d), .ENG_RD_IDX_I(ridx), .ENG_RD_DATA_O(erd), .IF_ON_O(on),
      .MASTER_O(mst), .AUTO_RATE_O(aut), .SLEEP_O(slp), .TX_SEL_O(txs), .SLAVE_ACK_O(ack),
      .WAKE_REQ_O(wup), .MASTER_GO_O(go), .STOP_O(stp), .IRQ_CLEAR_O(irq),
      .FAULT_CLEAR_O(flt), .SIZE_O(sz), .DIV_O(dv), .MUL_O(ml), .ID_O(id));

   task automatic chk(input logic [7:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: seen %h expected %h", $time, got, exp);
      end
   endtask

   task automatic report_and_stop();
      $display("checks %0d, failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   task automatic wr_reg(input logic [7:0] a, p, dat);
      cpu_i.access(1'b1, a, p, dat);
   endtask

   // note the expected answer, then keep the bus quiet until it is due
   task automatic rd_reg(input logic [7:0] a, p, e);
      q.push_back(e);
      cpu_i.access(1'b0, a, p, 8'h00);
      repeat (2) @(posedge clk);
   endtask

   task automatic wi(input logic [7:0] i, dat);
      wr_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, i);
      wr_reg(`LRA_ADDR_WIN, `LRA_PAGE_LIN, dat);
   endtask

   task automatic ri(input logic [7:0] i, e);
      wr_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, i);
      rd_reg(`LRA_ADDR_WIN, `LRA_PAGE_LIN, e);
   endtask

   task automatic ev(input logic [3:0] m);
      @(posedge clk) ev_r <= m;
      @(posedge clk) ev_r <= 4'h0;
      #1;
   endtask

   always @(posedge clk) begin
      if (rvalid === 1'b1) begin
         if (q.size() == 0) chk(rdata, 8'hxx);
         else chk(rdata, q.pop_front());
      end
   end

   initial begin
      #200000;
      n_fail++;
      report_and_stop();
   end

   initial begin
      logic [7:0] cfg [4] = '{8'hFF, 8'hBF, 8'h3F, 8'h1F};
      void'($urandom(32'h3e44));
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      #1 chk({on, mst, aut}, 3'b010);
      rd_reg(`LRA_ADDR_CFG, `LRA_PAGE_CFG, `LRA_RST_CFG);
      rd_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, 8'h00);
      // ---------------------------------------------------------
      // configuration bits and unused bits
      // ---------------------------------------------------------
      foreach (cfg[k]) begin
         v = cfg[k] ^ (8'($urandom) & 8'h1F);
         wr_reg(`LRA_ADDR_CFG, `LRA_PAGE_CFG, v);
         #1 chk({on, mst, aut}, {v[7], v[6], v[5] & ~v[6]});
         rd_reg(`LRA_ADDR_CFG, `LRA_PAGE_CFG, v & 8'hE0);
      end
      wr_reg(`LRA_ADDR_CFG, `LRA_PAGE_LIN, 8'hFF);
      rd_reg(`LRA_ADDR_CFG, `LRA_PAGE_CFG, 8'h00);
      wr_reg(`LRA_ADDR_CFG, `LRA_PAGE_CFG, 8'hC0);
      // ---------------------------------------------------------
      // pointer, indirect map, out-of-range pointer
      // ---------------------------------------------------------
      v = 8'($urandom) | 8'h10;
      wr_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, v);
      rd_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, v);
      wr_reg(`LRA_ADDR_PTR, `LRA_PAGE_CFG, ~v);
      rd_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, v);
      rd_reg(`LRA_ADDR_WIN, `LRA_PAGE_LIN, 8'h00);
      for (int i = 0; i < 15; i++) begin
         d[i] = 8'($urandom);
         if (i < 8 || i > 10) wi(8'(i), d[i]);
      end
      wi(8'h0F, 8'hFF);
      ri(8'h0F, 8'h00);
      for (int i = 0; i < 15; i++) begin
         v = (i == 11) ? `LRA_MASK_SIZE : (i == 14) ? `LRA_MASK_ID : 8'hFF;
         if (i < 8 || i > 10) ri(8'(i), d[i] & v);
      end
      chk(sz, d[11] & `LRA_MASK_SIZE);
      chk(dv, d[12]);
      chk(ml, d[13]);
      chk(id, d[14] & `LRA_MASK_ID);
      @(posedge clk) begin
         eng_we <= 1'b1;
         eidx <= 3'h3;
         eng_d <= ~d[3];
         ridx <= 3'h5;
      end
      @(posedge clk) eng_we <= 1'b0;
      #1 chk(erd, d[5]);
      ri(8'h03, ~d[3]);
      // ---------------------------------------------------------
      // master role: status, faults, control
      // ---------------------------------------------------------
      st <= 8'($urandom);
      fl <= 5'($urandom);
      #1 ri(`LRA_IDX_STAT, st & 8'hCF);
      ri(`LRA_IDX_FAULT, {3'h0, fl} & 8'h07);
      wi(`LRA_IDX_CTRL, 8'hFF);
      #1 chk({stp, irq, flt}, 3'b011);
      @(posedge clk) #1 chk({irq, flt}, 2'b00);
      chk({go, slp, txs, ack, wup}, 5'b10101);
      ri(`LRA_IDX_CTRL, 8'h23);
      ev(4'b1000);
      chk(go, 1'b0);
      wi(`LRA_IDX_CTRL, 8'h23);
      ev(4'b0101);
      chk({go, wup}, 2'b00);
      // ---------------------------------------------------------
      // slave role, software acknowledges a pending request
      // ---------------------------------------------------------
      wr_reg(`LRA_ADDR_CFG, `LRA_PAGE_CFG, 8'hA0);
      #1 chk({mst, aut}, 2'b01);
      st <= 8'h10;
      fl <= 5'h1F;
      wi(`LRA_IDX_CTRL, 8'hFF);
      #1 chk(stp, 1'b1);
      @(posedge clk) #1 chk({stp, go, slp, ack}, 4'b0011);
      ri(`LRA_IDX_CTRL, 8'h72);
      ev(4'b0010);
      ri(`LRA_IDX_CTRL, 8'h62);
      ri(`LRA_IDX_STAT, 8'h10);
      ri(`LRA_IDX_FAULT, 8'h1F);
      v = 8'($urandom);
      wi(8'h00, v);
      ri(8'h00, v);
      // frozen clock enable: a pointer write must not land
      @(posedge clk) ce <= 1'b0;
      wr_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, 8'h0E);
      @(posedge clk) ce <= 1'b1;
      rd_reg(`LRA_ADDR_PTR, `LRA_PAGE_LIN, 8'h00);
      repeat (4) @(posedge clk);
      chk(8'(q.size()), 8'h00);
      report_and_stop();
   end
endmodule // lra_top_tb
